/* rtl/pb_seq_defines.svh */
// timing constants and notes for the pushbutton power sequencer
// Notes on behaviour
// - in run or ramp-up states, button low 50 ms drives status low
// - status low holds at least its minimum pulse width, 50 ms
// - in run state, status releases about 900 us after button returns high
// - from off or hard reset, button low 400 ms enters ramp-up
// - from run or ramp-up, button low 5 s enters ramp-down, then hard reset
// - from off or hard reset, bus power present 100 ms enters ramp-up
// - in off with both enables low, raising either enables run after 900 us
// - buck turns off about 1 us after its enable falls
// - linear regulator turns off about 1 us after its enable falls
// - ramp-up lasts a fixed 5 s
// - ramp-down lasts a fixed 1 s
// - from off or hard reset, a press or bus power enables both regulators
// - order select picks which regulator starts first; second follows near regulation
// - in run or ramp-up states, status is a debounced buffered copy of the button input
`ifndef PB_SEQ_DEFINES_SVH
`define PB_SEQ_DEFINES_SVH
`define CLK_HZ 100000000
`define TICK_US 1
`define TICK_CYC (`CLK_HZ / 1000000 * `TICK_US)
`define T_STAT_LOW_MS 50
`define T_STAT_PW_MS 50
`define T_STAT_REL_US 900
`define T_PUP_PRESS_MS 400
`define T_HR_MS 5000
`define T_BUS_MS 100
`define T_RUN_UP_US 900
`define T_DIS_US 1
`define T_RAMPUP_MS 5000
`define T_RAMPDN_MS 1000
`define MS_TICKS(ms) ((ms) * 1000 / `TICK_US)
`define US_TICKS(us) ((us) / `TICK_US)
`endif

/* rtl/pb_seq_pkg.sv */
// types of the pushbutton power sequencer
package pb_seq_pkg;
   typedef enum logic [5:0] {
      off_state = 6'h01,
      hard_reset_state = 6'h02,
      rampup_state_a = 6'h04,
      rampup_state_b = 6'h08,
      run_state = 6'h10,
      rampdown_state_a = 6'h20
   } seq_state_type;
endpackage

/* rtl/sync_filter.sv */
// two-flop synchroniser with a fixed-delay falling edge filter
module sync_filter #(
   parameter int DELAY = 1
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic tick_i,
   input wire logic async_i,
   output logic sync_o,
   output logic slow_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic slow;
      logic [15:0] cnt;
   } sf_type;
   sf_type st_reg;
   sf_type st_next;
   if (DELAY < 1 || DELAY > 65535) begin : bad_delay
      $error("sync_filter DELAY out of range");
   end
   always_comb begin
      st_next = st_reg;
      st_next.s1 = async_i;
      st_next.s2 = st_reg.s1;
      if (st_reg.s2) begin
         st_next.slow = 1'b1;
         st_next.cnt = 16'h0000;
      end else if (st_reg.slow && tick_i) begin
         // fall seen only after the delay, rising is immediate
         if (st_reg.cnt >= 16'(DELAY - 1)) begin
            st_next.slow = 1'b0;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign sync_o = st_reg.s2;
   assign slow_o = st_reg.slow;
endmodule // sync_filter

/* rtl/pb_seq.sv */
// pushbutton power sequencer core
`include "pb_seq_defines.svh"
module pb_seq #(
   parameter int TICK_CYC = `TICK_CYC,
   parameter int PRESS_HR = `MS_TICKS(`T_HR_MS),
   parameter int RAMPUP = `MS_TICKS(`T_RAMPUP_MS),
   parameter int RAMPDN = `MS_TICKS(`T_RAMPDN_MS),
   parameter int PRESS_PUP = `MS_TICKS(`T_PUP_PRESS_MS),
   parameter int BUS_DLY = `MS_TICKS(`T_BUS_MS),
   parameter int STAT_LOW = `MS_TICKS(`T_STAT_LOW_MS),
   parameter int STAT_PW = `MS_TICKS(`T_STAT_PW_MS),
   parameter int STAT_REL = `US_TICKS(`T_STAT_REL_US),
   parameter int RUN_UP = `US_TICKS(`T_RUN_UP_US),
   parameter int DIS_DLY = `US_TICKS(`T_DIS_US)
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic button_n_i,
   input wire logic bus_power_i,
   input wire logic buck_enable_i,
   input wire logic linear_enable_i,
   input wire logic order_select_i,
   input wire logic buck_good_i,
   input wire logic linear_good_i,
   output logic status_o,
   output logic status_oe_o,
   output logic buck_on_o,
   output logic linear_on_o,
   output logic [5:0] state_o
);
   localparam int CW = 24;
   // the tick divider is 16 bits wide, every duration counter CW bits
   if (TICK_CYC < 1 || TICK_CYC > 65536 || PRESS_HR < 2 || PRESS_HR >= 2 ** CW ||
       RAMPUP >= 2 ** CW || RAMPDN >= 2 ** CW) begin : bad_param
      $error("pb_seq: parameter out of range");
   end
   typedef struct packed {
      pb_seq_pkg::seq_state_type state;
      logic [15:0] tick_cnt;
      logic tick;
      logic [CW-1:0] press_cnt;
      logic [CW-1:0] state_cnt;
      logic [CW-1:0] bus_cnt;
      logic [CW-1:0] stat_cnt;
      logic [CW-1:0] rel_cnt;
      logic status_low;
      logic buck_on;
      logic linear_on;
      logic hr_done;
   } core_type;
   core_type st_reg;
   core_type st_next;
   logic btn_s, bus_s, seq_s, bgood_s, lgood_s, buck_s, lin_s, buck_slow, lin_slow;
   ////////////////////////////////////////////////////////////////////////
   sync_filter #(.DELAY(DIS_DLY)) buck_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(buck_enable_i), .sync_o(buck_s), .slow_o(buck_slow));
   sync_filter #(.DELAY(DIS_DLY)) lin_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(linear_enable_i), .sync_o(lin_s), .slow_o(lin_slow));
   // button inverted ahead of the flops: their reset level then reads as released
   sync_filter #(.DELAY(1)) btn_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(~button_n_i), .sync_o(btn_s), .slow_o());
   sync_filter #(.DELAY(1)) bus_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(bus_power_i), .sync_o(bus_s), .slow_o());
   sync_filter #(.DELAY(1)) seq_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(order_select_i), .sync_o(seq_s), .slow_o());
   sync_filter #(.DELAY(1)) bg_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(buck_good_i), .sync_o(bgood_s), .slow_o());
   sync_filter #(.DELAY(1)) lg_sf (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .tick_i(st_reg.tick), .async_i(linear_good_i), .sync_o(lgood_s), .slow_o());
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic pressed;
      logic en_any;
      logic in_up;
      pressed = 1'b0;
      en_any = 1'b0;
      in_up = 1'b0;
      st_next = st_reg;
      st_next.tick = 1'b0;
      // timebase tick
      if (st_reg.tick_cnt >= 16'(TICK_CYC - 1)) begin
         st_next.tick_cnt = 16'h0000;
         st_next.tick = 1'b1;
      end else begin
         st_next.tick_cnt = st_reg.tick_cnt + 16'h0001;
      end
      pressed = btn_s;
      en_any = buck_s | lin_s;
      in_up = (st_reg.state == pb_seq_pkg::rampup_state_a) ||
              (st_reg.state == pb_seq_pkg::rampup_state_b);
      // press duration counter, saturating
      if (!pressed) begin
         st_next.press_cnt = '0;
         st_next.hr_done = 1'b0;
      end else if (st_reg.tick && st_reg.press_cnt != '1) begin
         st_next.press_cnt = st_reg.press_cnt + 1'b1;
      end
      if (!bus_s) begin
         st_next.bus_cnt = '0;
      end else if (st_reg.tick && st_reg.bus_cnt != '1) begin
         st_next.bus_cnt = st_reg.bus_cnt + 1'b1;
      end
      if (st_reg.tick && st_reg.state_cnt != '1) begin
         st_next.state_cnt = st_reg.state_cnt + 1'b1;
      end
      // status output: debounced copy of the button in ramp-up and run states
      if (st_reg.status_low && st_reg.tick && st_reg.stat_cnt != '1) begin
         st_next.stat_cnt = st_reg.stat_cnt + 1'b1;
      end
      if (!st_reg.status_low) begin
         if ((in_up || st_reg.state == pb_seq_pkg::run_state) &&
             st_reg.press_cnt >= CW'(STAT_LOW)) begin
            st_next.status_low = 1'b1;
            st_next.stat_cnt = '0;
         end
      end else if (st_reg.stat_cnt >= CW'(STAT_PW) && !pressed) begin
         // release waits for the pulse width first
         if (st_reg.tick) begin
            st_next.rel_cnt = st_reg.rel_cnt + 1'b1;
         end
         if (st_reg.rel_cnt >= CW'(STAT_REL)) begin
            st_next.status_low = 1'b0;
            st_next.rel_cnt = '0;
         end
      end else begin
         st_next.rel_cnt = '0;
      end
      // regulator enables follow their inputs, dropping after the filter
      if (st_reg.state == pb_seq_pkg::run_state) begin
         st_next.buck_on = buck_slow;
         st_next.linear_on = lin_slow;
      end
      unique case (st_reg.state)
         pb_seq_pkg::off_state, pb_seq_pkg::hard_reset_state: begin
            st_next.buck_on = 1'b0;
            st_next.linear_on = 1'b0;
            if ((st_reg.press_cnt >= CW'(PRESS_PUP) && !st_reg.hr_done) ||
                st_reg.bus_cnt >= CW'(BUS_DLY)) begin
               st_next.state = pb_seq_pkg::rampup_state_a;
               st_next.state_cnt = '0;
               st_next.bus_cnt = '0;
               st_next.press_cnt = '0;
               // first regulator comes on with the state, not a cycle later
               st_next.buck_on = !seq_s;
               st_next.linear_on = seq_s;
            end else if (st_reg.state == pb_seq_pkg::off_state) begin
               // power-on delay from off: time runs only while an enable is high
               if (!en_any) begin
                  st_next.state_cnt = '0;
               end else if (st_reg.state_cnt >= CW'(RUN_UP)) begin
                  st_next.state = pb_seq_pkg::run_state;
                  st_next.buck_on = buck_slow;
                  st_next.linear_on = lin_slow;
               end
            end
         end
         pb_seq_pkg::rampup_state_a: begin
            // first regulator by order select, second after it nears regulation
            st_next.buck_on = !seq_s;
            st_next.linear_on = seq_s;
            if (seq_s ? lgood_s : bgood_s) begin
               st_next.state = pb_seq_pkg::rampup_state_b;
               st_next.buck_on = 1'b1;
               st_next.linear_on = 1'b1;
            end
         end
         pb_seq_pkg::rampup_state_b: begin
            st_next.buck_on = 1'b1;
            st_next.linear_on = 1'b1;
         end
         pb_seq_pkg::run_state: begin
            if (!buck_slow && !lin_slow) begin
               st_next.state = pb_seq_pkg::off_state;
            end
         end
         pb_seq_pkg::rampdown_state_a: begin
            // power-down: regulators held off for a fixed time, then hard reset
            st_next.buck_on = 1'b0;
            st_next.linear_on = 1'b0;
            if (st_reg.state_cnt >= CW'(RAMPDN)) begin
               st_next.state = pb_seq_pkg::hard_reset_state;
            end
         end
      endcase
      if (in_up && st_reg.state_cnt >= CW'(RAMPUP)) begin
         st_next.state = pb_seq_pkg::run_state;
      end
      if ((in_up || st_reg.state == pb_seq_pkg::run_state) && !st_reg.hr_done &&
          st_reg.press_cnt >= CW'(PRESS_HR)) begin
         st_next.state = pb_seq_pkg::rampdown_state_a;
         st_next.state_cnt = '0;
         st_next.hr_done = 1'b1;
         st_next.buck_on = 1'b0;
         st_next.linear_on = 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         st_reg <= '{state: pb_seq_pkg::off_state, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end
   assign status_o = 1'b0;
   assign status_oe_o = st_reg.status_low;
   assign buck_on_o = st_reg.buck_on;
   assign linear_on_o = st_reg.linear_on;
   assign state_o = st_reg.state;
   ////////////////////////////////////////////////////////////////////////
   stat_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(status_oe_o) |=> status_oe_o [*8]) else $error("status low too short");
   stat_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(status_oe_o) |-> $past(st_reg.press_cnt) >= CW'(STAT_LOW))
      else $error("status low without press");
   up_enter_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(state_o == pb_seq_pkg::rampup_state_a) |-> $past(st_reg.press_cnt) >= CW'(PRESS_PUP)
      || $past(st_reg.bus_cnt) >= CW'(BUS_DLY)) else $error("ramp-up without cause");
   hr_enter_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(state_o == pb_seq_pkg::hard_reset_state) |-> !buck_on_o && !linear_on_o)
      else $error("hard reset left regulators on");
   down_enter_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(state_o == pb_seq_pkg::rampdown_state_a) |-> !buck_on_o && !linear_on_o &&
      $past(st_reg.press_cnt) >= CW'(PRESS_HR)) else $error("power-down without long press");
   down_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(state_o == pb_seq_pkg::hard_reset_state) |-> $past(state_o) ==
      pb_seq_pkg::rampdown_state_a && $past(st_reg.state_cnt) >= CW'(RAMPDN))
      else $error("power-down cut short");
   first_reg_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_o == pb_seq_pkg::rampup_state_a && $past(state_o) == pb_seq_pkg::rampup_state_a
      |-> buck_on_o != linear_on_o) else $error("ramp-up order broken");
   both_up_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_o == pb_seq_pkg::rampup_state_b ##1 state_o == pb_seq_pkg::rampup_state_b
      |-> buck_on_o && linear_on_o) else $error("second regulator not enabled");
   off_regs_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_o == pb_seq_pkg::off_state ##1 state_o == pb_seq_pkg::off_state
      |-> !buck_on_o && !linear_on_o) else $error("regulator on in off state");
   run_entry_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $rose(state_o == pb_seq_pkg::run_state) |-> $past(st_reg.state_cnt) >= CW'(RUN_UP))
      else $error("run state entered early");
endmodule // pb_seq

/* test/pb_seq_regulator_model.sv */
// regulator feedback model: reports near regulation some cycles after each enable
module pb_seq_regulator_model (
   input wire logic clk_sys_i,
   input wire logic [7:0] good_dly_i,
   input wire logic buck_on_i,
   input wire logic linear_on_i,
   output logic buck_good_o,
   output logic linear_good_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int buck_cnt = 0;
   int linear_cnt = 0;
   // good drops on the first clock edge after disable, so no stale level survives a restart
   always @(posedge clk_sys_i) begin
      buck_cnt <= buck_on_i ? buck_cnt + 1 : 0;
      linear_cnt <= linear_on_i ? linear_cnt + 1 : 0;
   end
   assign buck_good_o = (buck_cnt >= int'(good_dly_i));
   assign linear_good_o = (linear_cnt >= int'(good_dly_i));
endmodule // pb_seq_regulator_model

/* test/pb_seq_bench.sv */
// self-checking bench for the pushbutton power sequencer
module pb_seq_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HR = 200, RUP = 100, PUP = 40, BUS = 20, SLO = 10, SPW = 10, SREL = 5, RUN = 5;
   localparam int RDN = 50;
   typedef struct packed {logic bus; logic order; logic [7:0] dly;} row_type;
   row_type rows [4] = '{'{1'h1, 1'h0, 8'h04}, '{1'h1, 1'h1, 8'h1E},
                         '{1'h0, 1'h0, 8'h1E}, '{1'h0, 1'h1, 8'h04}};
   logic clk_sys_i = 1'h0, reset_i = 1'h1, button_n_i = 1'h1, bus_power_i = 1'h0;
   logic buck_enable_i = 1'h0, linear_enable_i = 1'h0, order_select_i = 1'h0;
   logic [7:0] good_dly = 8'h04;
   logic buck_good, linear_good, status_o, status_oe_o, buck_on_o, linear_on_o;
   logic [5:0] state_o;
   int err_total = 0, tests_run = 0, c1, c2;
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
   always #5 clk_sys_i = ~clk_sys_i;
   pb_seq #(.TICK_CYC(1), .PRESS_HR(HR), .RAMPUP(RUP), .RAMPDN(RDN), .PRESS_PUP(PUP),
      .BUS_DLY(BUS), .STAT_LOW(SLO), .STAT_PW(SPW), .STAT_REL(SREL), .RUN_UP(RUN),
      .DIS_DLY(1)) pb_seq_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .button_n_i(button_n_i), .bus_power_i(bus_power_i), .buck_enable_i(buck_enable_i),
      .linear_enable_i(linear_enable_i), .order_select_i(order_select_i),
      .buck_good_i(buck_good), .linear_good_i(linear_good), .status_o(status_o),
      .status_oe_o(status_oe_o), .buck_on_o(buck_on_o), .linear_on_o(linear_on_o),
      .state_o(state_o));
   pb_seq_regulator_model pb_seq_regulator_model_i (.clk_sys_i(clk_sys_i),
      .good_dly_i(good_dly), .buck_on_i(buck_on_o), .linear_on_i(linear_on_o),
      .buck_good_o(buck_good), .linear_good_o(linear_good));
   function automatic logic [5:0] pick(input int w);
      case (w)
         0: pick = state_o;
         1: pick = {5'h00, status_oe_o};
         2: pick = {5'h00, buck_on_o};
         default: pick = {5'h00, linear_on_o};
      endcase
   endfunction
   // bounded wait, counted in clock edges
   task automatic wait_sig(input int w, input logic [5:0] want, output int c);
      c = 0;
      while (pick(w) !== want && c < 400) begin
         @(posedge clk_sys_i);
         #1;
         c++;
      end
   endtask
   task automatic span(input string nm, input int c, input int lo, input int hi);
      `CHECK(nm, 1'h1, (c >= lo && c <= hi))
   endtask
   task automatic do_reset();
      @(posedge clk_sys_i);
      reset_i <= 1'h1;
      {button_n_i, bus_power_i, buck_enable_i, linear_enable_i} <= 4'h8;
      repeat (6) @(posedge clk_sys_i);
      reset_i <= 1'h0;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic complete_run();
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      complete_run();
   end
   initial begin
      foreach (rows[i]) begin
         do_reset();
         @(posedge clk_sys_i);
         order_select_i <= rows[i].order;
         good_dly <= rows[i].dly;
         if (rows[i].bus) bus_power_i <= 1'h1;
         else button_n_i <= 1'h0;
         wait_sig(0, 6'h04, c1);
         span("rampup entry", c1, rows[i].bus ? BUS - 1 : PUP - 1,
            rows[i].bus ? BUS + 8 : PUP + 8);
         `CHECK("first on", 1'h1, rows[i].order ? linear_on_o : buck_on_o)
         `CHECK("second off", 1'h0, rows[i].order ? buck_on_o : linear_on_o)
         @(posedge clk_sys_i);
         button_n_i <= 1'h1;
         wait_sig(0, 6'h08, c1);
         span("second wait", c1, int'(rows[i].dly) - 1, int'(rows[i].dly) + 8);
         `CHECK("both on", 2'h3, {buck_on_o, linear_on_o})
         @(posedge clk_sys_i);
         {buck_enable_i, linear_enable_i} <= 2'h3;
         wait_sig(0, 6'h10, c2);
         span("rampup length", c1 + c2, RUP - 2, RUP + int'(rows[i].dly) + 10);
         @(posedge clk_sys_i);
         bus_power_i <= 1'h0;
      end
      // short press: width floor holds the status low after release
      @(posedge clk_sys_i);
      button_n_i <= 1'h0;
      wait_sig(1, 6'h01, c1);
      span("status assert", c1, SLO - 1, SLO + 6);
      `CHECK("status data", 1'h0, status_o)
      @(posedge clk_sys_i);
      button_n_i <= 1'h1;
      wait_sig(1, 6'h00, c1);
      span("status width", c1, SPW - 2, SPW + SREL + 8);
      // long press: release delay measured from the button edge
      @(posedge clk_sys_i);
      button_n_i <= 1'h0;
      repeat (3 * SPW + SLO) @(posedge clk_sys_i);
      button_n_i <= 1'h1;
      wait_sig(1, 6'h00, c1);
      span("status release", c1, SREL - 1, SREL + 6);
      @(posedge clk_sys_i);
      buck_enable_i <= 1'h0;
      wait_sig(2, 6'h00, c1);
      span("buck off", c1, 1, 6);
      `CHECK("linear kept", 1'h1, linear_on_o)
      @(posedge clk_sys_i);
      linear_enable_i <= 1'h0;
      wait_sig(3, 6'h00, c1);
      span("linear off", c1, 1, 6);
      wait_sig(0, 6'h01, c1);
      `CHECK("back off", 6'h01, state_o)
      @(posedge clk_sys_i);
      linear_enable_i <= 1'h1;
      wait_sig(0, 6'h10, c1);
      span("run up", c1, RUN - 1, RUN + 8);
      `CHECK("linear run", 1'h1, linear_on_o)
      @(posedge clk_sys_i);
      button_n_i <= 1'h0;
      wait_sig(0, 6'h20, c1);
      span("hard reset", c1, HR - 1, HR + 8);
      `CHECK("down regs off", 2'h0, {buck_on_o, linear_on_o})
      wait_sig(0, 6'h02, c1);
      span("power down", c1, RDN - 1, RDN + 3);
      `CHECK("hr regs off", 2'h0, {buck_on_o, linear_on_o})
      @(posedge clk_sys_i);
      {button_n_i, linear_enable_i} <= 2'h2;
      @(posedge clk_sys_i);
      bus_power_i <= 1'h1;
      wait_sig(0, 6'h04, c1);
      span("bus from hr", c1, BUS - 1, BUS + 8);
      // reset in mid ramp-up must drop everything at once
      do_reset();
      `CHECK("reset state", 6'h01, state_o)
      `CHECK("reset outs", 3'h0, {status_oe_o, buck_on_o, linear_on_o})
      complete_run();
   end
endmodule // pb_seq_bench
